// ==== rsp_defines.svh ====
/*
 * constants of the reset-strap pin configuration block: register offsets,
 * field positions, reset values and pin positions.
 * assumes inclusion by bare name from the package and the design modules.
 */
`ifndef RSP_DEFINES_SVH
`define RSP_DEFINES_SVH

`define RSP_ADDR_W 8
`define RSP_DATA_W 32

`define RSP_OFF_CTRL 8'h00
`define RSP_OFF_FLAG_DIR 8'h04
`define RSP_OFF_FLAG_OUT 8'h08
`define RSP_OFF_FLAG_IN 8'h0c
`define RSP_OFF_STATUS 8'h10
`define RSP_OFF_INT_STAT 8'h14
`define RSP_OFF_INT_MASK 8'h18

`define RSP_CTRL_W 4
`define RSP_CTRL_ALT_BIT 0
`define RSP_CTRL_CONFIGURABLE_IRQ_PIN_EDGE_BIT 1
`define RSP_CTRL_SIRQ0_EDGE_BIT 2
`define RSP_CTRL_SIRQ1_EDGE_BIT 3
`define RSP_CTRL_RST 4'h0

`define RSP_FLAG_DIR_RST 8'h00
`define RSP_FLAG_OUT_RST 9'h000
`define RSP_FO_BIT 8
`define RSP_FI_BIT 8

`define RSP_STAT_HOST_BIT 0
`define RSP_STAT_GRANT_BIT 1
`define RSP_STAT_HUNG_BIT 2

`define RSP_INT_N 6
`define RSP_INT_MASK_RST 6'h00
`define RSP_INT_STAT_RST 6'h00

`define RSP_STRAP_PIN 2
`define RSP_PIN_EDGE_IRQ_PIN 4
`define RSP_PIN_LEVEL_IRQ_ZERO 5
`define RSP_PIN_LEVEL_IRQ_ONE 6
`define RSP_PIN_CONFIGURABLE_IRQ_PIN 7

`define RSP_SP_IRQ0 0
`define RSP_SP_IRQ1 1
`define RSP_SP_FI 2
`define RSP_SP_FO 3
`define RSP_SP_ALT_OE 5'h08

`endif

// ==== rsp_pkg.sv ====
/*
 * types of the reset-strap pin configuration block.
 * assumes rsp_defines.svh is on the include path.
 */
`include "rsp_defines.svh"

package rsp_pkg;
   typedef enum logic {
      MODE_FULL = 1'b0,
      MODE_HOST = 1'b1
   } rsp_mode_e;

   typedef enum logic [1:0] {
      BUS_OWN = 2'b00,
      BUS_GRANT = 2'b01,
      BUS_HUNG = 2'b11
   } rsp_bus_e;

   typedef logic [`RSP_INT_N-1:0] rsp_int_t;
endpackage

// ==== rsp_irq_if.sv ====
/*
 * interface between the main block and its interrupt detector.
 * assumes one clock domain; pin levels are active low.
 */
`timescale 1ns/1ps

interface rsp_irq_if #(parameter int N = 6);
   logic [N-1:0] level_n;
   logic [N-1:0] edge_mode;
   logic [N-1:0] evt;

   modport det (
      input level_n,
      input edge_mode,
      output evt
   );

   modport core (
      output level_n,
      output edge_mode,
      input evt
   );
endinterface

// ==== rsp_irq_detect.sv ====
/*
 * interrupt detector: per input, level or falling-edge event.
 * assumes inputs synchronous to clk, active low.
 */
`timescale 1ns/1ps

module rsp_irq_detect #(
   parameter int N = 6
) (
   input wire logic clk,
   input wire logic sys_rst,
   rsp_irq_if.det irq
);
   logic [N-1:0] prev_r;
   logic [N-1:0] fall;
   logic [N-1:0] low;

   // previous level, idle high
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prev_r <= '1;
      end else begin
         prev_r <= irq.level_n;
      end
   end

   assign fall = prev_r & ~irq.level_n;
   assign low = ~irq.level_n;
   assign irq.evt = (irq.edge_mode & fall) | (~irq.edge_mode & low);
endmodule

// ==== rsp_pin_config.sv ====
/*
 * reset-strap pin configuration: strap capture, memory-bus muxing for the
 * two memory modes, host port pins, shared interrupt/flag pins, second
 * serial port alternate use, bus request/grant, registers and interrupt.
 * assumes all pin inputs synchronous to clk; two-way pins resolved outside.
 */
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "rsp_defines.svh"

module rsp_pin_config #(
   parameter int INT_N = `RSP_INT_N
) (
   input wire logic clk,
   input wire logic sys_rst,
   // register port
   input wire logic [`RSP_ADDR_W-1:0] reg_addr,
   input wire logic [`RSP_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`RSP_DATA_W-1:0] reg_rdata,
   output logic irq_out,
   // flag pins, 7..4 shared with interrupts, pin 2 the strap
   input wire logic [7:0] flag_pin_in,
   output logic [7:0] flag_pin_out,
   output logic [7:0] flag_pin_oe,
   // core memory access
   input wire logic core_mem_req,
   input wire logic core_mem_we,
   input wire logic core_byte_acc,
   input wire logic [13:0] core_addr,
   input wire logic [7:0] core_byte_page,
   input wire logic [23:0] core_wdata,
   output logic [23:0] core_rdata,
   // external memory bus
   output logic [13:0] ext_address_bus,
   input wire logic [23:0] ext_data_bus_in,
   output logic [23:0] ext_data_bus_out,
   output logic [23:0] ext_data_bus_oe,
   // host port
   input wire logic host_port_select_n,
   input wire logic host_read_strobe_n,
   input wire logic host_write_strobe_n,
   input wire logic host_addr_latch,
   input wire logic [15:0] host_addr_data_bus_in,
   output logic [15:0] host_addr_data_bus_out,
   output logic [15:0] host_addr_data_bus_oe,
   output logic host_port_ack_n,
   input wire logic [15:0] host_dma_rdata,
   output logic [15:0] host_dma_addr,
   output logic [15:0] host_dma_wdata,
   output logic host_dma_wr,
   // second serial port pins and core side
   input wire logic [4:0] second_serial_port_in,
   output logic [4:0] second_serial_port_out,
   output logic [4:0] second_serial_port_oe,
   input wire logic [4:0] sp_core_out,
   input wire logic [4:0] sp_core_oe,
   output logic [4:0] sp_core_in,
   // bus request / grant
   input wire logic bus_request_in_n,
   output logic bus_grant_out_n,
   output logic grant_hung_out_n
);
   // registers
   logic run_r;
   logic strap_r;
   logic [`RSP_CTRL_W-1:0] ctrl_r;
   logic [7:0] flag_dir_r;
   logic [8:0] flag_out_r;
   rsp_pkg::rsp_int_t int_stat_r;
   rsp_pkg::rsp_int_t int_mask_r;
   rsp_pkg::rsp_bus_e bus_r;
   rsp_pkg::rsp_bus_e bus_nxt;
   logic host_wr_prev_r;

   // decode
   wire wr_ctrl = reg_hit(reg_wr, reg_addr, `RSP_OFF_CTRL);
   wire wr_dir = reg_hit(reg_wr, reg_addr, `RSP_OFF_FLAG_DIR);
   wire wr_fout = reg_hit(reg_wr, reg_addr, `RSP_OFF_FLAG_OUT);
   wire wr_istat = reg_hit(reg_wr, reg_addr, `RSP_OFF_INT_STAT);
   wire wr_interrupt_mask_reg = reg_hit(reg_wr, reg_addr, `RSP_OFF_INT_MASK);

   function automatic logic reg_hit(input logic stb, input logic [`RSP_ADDR_W-1:0] a,
                                    input logic [`RSP_ADDR_W-1:0] off);
      reg_hit = stb && (a == off);
   endfunction

   // mode from captured strap
   rsp_pkg::rsp_mode_e mode;
   assign mode = rsp_pkg::rsp_mode_e'(strap_r);
   wire host_mode = run_r && (mode == rsp_pkg::MODE_HOST);
   wire alt_en = ctrl_r[`RSP_CTRL_ALT_BIT];
   wire granted = (bus_r != rsp_pkg::BUS_OWN);

   // run flag: low in reset, high from the first edge after release
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         run_r <= 1'b0;
      end else begin
         run_r <= 1'b1;
      end
   end

   // strap follows the pin in reset and at the release edge, then frozen
   always_ff @(posedge clk) begin
      if (!run_r) begin
         strap_r <= flag_pin_in[`RSP_STRAP_PIN];
      end
   end

   // control registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_r <= `RSP_CTRL_RST;
         flag_dir_r <= `RSP_FLAG_DIR_RST;
         flag_out_r <= `RSP_FLAG_OUT_RST;
         int_mask_r <= `RSP_INT_MASK_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= reg_wdata[`RSP_CTRL_W-1:0];
         end
         if (wr_dir) begin
            flag_dir_r <= reg_wdata[7:0];
         end
         if (wr_fout) begin
            flag_out_r <= reg_wdata[8:0];
         end
         if (wr_interrupt_mask_reg) begin
            int_mask_r <= reg_wdata[INT_N-1:0];
         end
      end
   end

   // flag pins: inputs in reset, programmable afterwards
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         flag_pin_oe <= 8'h00;
         flag_pin_out <= 8'h00;
      end else begin
         flag_pin_oe <= run_r ? flag_dir_r : 8'h00;
         flag_pin_out <= flag_out_r[7:0];
      end
   end

   // level seen by the interrupt logic, own drive included
   wire [7:0] flag_lvl = (flag_pin_oe & flag_pin_out) | (~flag_pin_oe & flag_pin_in);

   // second serial port pin muxing
   wire [4:0] sp_alt_out = 5'(flag_out_r[`RSP_FO_BIT]) << `RSP_SP_FO;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         second_serial_port_out <= 5'h00;
         second_serial_port_oe <= 5'h00;
         sp_core_in <= 5'h00;
      end else begin
         second_serial_port_out <= alt_en ? sp_alt_out : sp_core_out;
         second_serial_port_oe <= alt_en ? `RSP_SP_ALT_OE : sp_core_oe;
         sp_core_in <= second_serial_port_in;
      end
   end

   // interrupt detection
   rsp_irq_if #(.N(INT_N)) irq_bus ();

   wire sirq0_n = alt_en ? second_serial_port_in[`RSP_SP_IRQ0] : 1'b1;
   wire sirq1_n = alt_en ? second_serial_port_in[`RSP_SP_IRQ1] : 1'b1;

   assign irq_bus.level_n = {sirq1_n, sirq0_n, flag_lvl[`RSP_PIN_EDGE_IRQ_PIN],
                             flag_lvl[`RSP_PIN_LEVEL_IRQ_ONE], flag_lvl[`RSP_PIN_LEVEL_IRQ_ZERO],
                             flag_lvl[`RSP_PIN_CONFIGURABLE_IRQ_PIN]};
   assign irq_bus.edge_mode = {ctrl_r[`RSP_CTRL_SIRQ1_EDGE_BIT],
                               ctrl_r[`RSP_CTRL_SIRQ0_EDGE_BIT], 1'b1, 1'b0, 1'b0,
                               ctrl_r[`RSP_CTRL_CONFIGURABLE_IRQ_PIN_EDGE_BIT]};

   rsp_irq_detect #(.N(INT_N)) u_irq_detect (
      .clk(clk),
      .sys_rst(sys_rst),
      .irq(irq_bus)
   );

   // sticky status, set wins over clear
   wire [INT_N-1:0] istat_clr = wr_istat ? reg_wdata[INT_N-1:0] : '0;
   wire [INT_N-1:0] istat_nxt = (int_stat_r & ~istat_clr) | (irq_bus.evt & {INT_N{run_r}});

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         int_stat_r <= `RSP_INT_STAT_RST;
         irq_out <= 1'b0;
      end else begin
         int_stat_r <= istat_nxt;
         irq_out <= |(int_stat_r & int_mask_r);
      end
   end

   // bus request / grant
   always_comb begin
      bus_nxt = bus_r;
      case (bus_r)
         rsp_pkg::BUS_OWN: begin
            if (!bus_request_in_n && !core_mem_req) begin
               bus_nxt = rsp_pkg::BUS_GRANT;
            end
         end
         rsp_pkg::BUS_GRANT: begin
            if (bus_request_in_n) begin
               bus_nxt = rsp_pkg::BUS_OWN;
            end else if (core_mem_req) begin
               bus_nxt = rsp_pkg::BUS_HUNG;
            end
         end
         rsp_pkg::BUS_HUNG: begin
            if (bus_request_in_n) begin
               bus_nxt = rsp_pkg::BUS_OWN;
            end else if (!core_mem_req) begin
               bus_nxt = rsp_pkg::BUS_GRANT;
            end
         end
         default: begin
            bus_nxt = rsp_pkg::BUS_OWN;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_r <= rsp_pkg::BUS_OWN;
         bus_grant_out_n <= 1'b1;
         grant_hung_out_n <= 1'b1;
      end else begin
         bus_r <= bus_nxt;
         bus_grant_out_n <= (bus_nxt == rsp_pkg::BUS_OWN);
         grant_hung_out_n <= (bus_nxt != rsp_pkg::BUS_HUNG);
      end
   end

   // external memory bus muxing
   wire drive_ok = core_mem_req && !granted && run_r;
   wire [13:0] full_addr = core_addr;
   wire [23:0] full_dout = core_byte_acc ? {core_byte_page, core_wdata[15:0]} : core_wdata;
   wire [23:0] full_oe = core_mem_we ? 24'hffffff : (core_byte_acc ? 24'hff0000 : 24'h000000);
   wire [13:0] host_addr = {13'h0000, core_addr[0]};
   wire [23:0] host_dout = {core_wdata[23:8], 8'h00};
   wire [23:0] host_oe = core_mem_we ? 24'hffff00 : 24'h000000;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ext_address_bus <= 14'h0000;
         ext_data_bus_out <= 24'h000000;
         ext_data_bus_oe <= 24'h000000;
         core_rdata <= 24'h000000;
      end else begin
         ext_address_bus <= !drive_ok ? 14'h0000 : (host_mode ? host_addr : full_addr);
         ext_data_bus_out <= host_mode ? host_dout : full_dout;
         ext_data_bus_oe <= !drive_ok ? 24'h000000 : (host_mode ? host_oe : full_oe);
         core_rdata <= host_mode ? {ext_data_bus_in[23:8], 8'h00} : ext_data_bus_in;
      end
   end

   // host port, active only in host mode
   wire host_sel = host_mode && !host_port_select_n;
   wire host_rd = host_sel && !host_read_strobe_n;
   wire host_wr = host_sel && !host_write_strobe_n;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         host_dma_addr <= 16'h0000;
         host_dma_wdata <= 16'h0000;
         host_dma_wr <= 1'b0;
         host_wr_prev_r <= 1'b0;
         host_port_ack_n <= 1'b1;
         host_addr_data_bus_out <= 16'h0000;
         host_addr_data_bus_oe <= 16'h0000;
      end else begin
         if (host_sel && host_addr_latch) begin
            host_dma_addr <= host_addr_data_bus_in;
         end
         if (host_wr) begin
            host_dma_wdata <= host_addr_data_bus_in;
         end
         host_wr_prev_r <= host_wr;
         host_dma_wr <= host_wr_prev_r && !host_wr;
         host_port_ack_n <= !(host_rd || host_wr);
         host_addr_data_bus_out <= host_dma_rdata;
         host_addr_data_bus_oe <= host_rd ? 16'hffff : 16'h0000;
      end
   end

   // register read, data in the cycle after the strobe
   wire [`RSP_DATA_W-1:0] rd_status = {29'h00000000, (bus_r == rsp_pkg::BUS_HUNG),
                                        granted, host_mode};
   wire [`RSP_DATA_W-1:0] rd_flag_in = {23'h000000, second_serial_port_in[`RSP_SP_FI],
                                         flag_pin_in};
   logic [`RSP_DATA_W-1:0] rd_mux;

   always_comb begin
      case (reg_addr)
         `RSP_OFF_CTRL: rd_mux = {28'h0000000, ctrl_r};
         `RSP_OFF_FLAG_DIR: rd_mux = {24'h000000, flag_dir_r};
         `RSP_OFF_FLAG_OUT: rd_mux = {23'h000000, flag_out_r};
         `RSP_OFF_FLAG_IN: rd_mux = rd_flag_in;
         `RSP_OFF_STATUS: rd_mux = rd_status;
         `RSP_OFF_INT_STAT: rd_mux = {26'h0000000, int_stat_r};
         `RSP_OFF_INT_MASK: rd_mux = {26'h0000000, int_mask_r};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 32'h00000000;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
      end
   end
endmodule

// ==== rsp_pin_config_props.sv ====
/* checker of the pin configuration block's port timing.
   assumes a bind to rsp_pin_config and one clock domain. */
`timescale 1ns/1ps
`include "rsp_defines.svh"

module rsp_pin_config_props #(
   parameter int INT_N = `RSP_INT_N
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [`RSP_ADDR_W-1:0] reg_addr,
   input wire logic [`RSP_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic [7:0] flag_pin_in,
   input wire logic [7:0] flag_pin_oe,
   input wire logic core_mem_req,
   input wire logic core_mem_we,
   input wire logic [13:0] core_addr,
   input wire logic [13:0] ext_address_bus,
   input wire logic [23:0] ext_data_bus_oe,
   input wire logic host_port_select_n,
   input wire logic host_read_strobe_n,
   input wire logic host_port_ack_n,
   input wire logic [4:0] second_serial_port_oe,
   input wire logic bus_request_in_n,
   input wire logic bus_grant_out_n,
   input wire logic grant_hung_out_n
);
   logic run_r;
   logic mode_r;

   // copy of the strap: in reset and on the first edge after
   always_ff @(posedge clk) begin
      if (sys_rst || !run_r) begin
         mode_r <= flag_pin_in[2];
      end
      run_r <= !sys_rst;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_oe_in_reset: assert property (disable iff (1'b0) sys_rst |-> flag_pin_oe == 8'h00)
      else $error("flag pin driven in reset");
   chk_grant_on: assert property (!bus_request_in_n && !core_mem_req |=> !bus_grant_out_n)
      else $error("bus not granted");
   chk_grant_off: assert property (bus_request_in_n |=> bus_grant_out_n)
      else $error("grant not released");
   chk_hung_flag: assert property (!bus_grant_out_n && !bus_request_in_n && core_mem_req
      |=> !grant_hung_out_n)
      else $error("hung not flagged");
   chk_mem_oe: assert property (run_r && bus_grant_out_n && core_mem_req && core_mem_we
      |=> ext_data_bus_oe == (mode_r ? 24'hffff00 : 24'hffffff))
      else $error("data enables wrong for mode");
   chk_mem_addr: assert property (run_r && bus_grant_out_n && core_mem_req
      |=> ext_address_bus == (mode_r ? ($past(core_addr) & 14'h0001) : $past(core_addr)))
      else $error("address wrong for mode");
   chk_serial_alt: assert property (reg_wr && reg_addr == `RSP_OFF_CTRL
      && reg_wdata[`RSP_CTRL_ALT_BIT] |-> ##2 second_serial_port_oe == 5'h08)
      else $error("serial alternate enables wrong");
   chk_ack_host: assert property (run_r && mode_r && !host_port_select_n && !host_read_strobe_n
      |=> !host_port_ack_n)
      else $error("host ack missing");
endmodule

bind rsp_pin_config rsp_pin_config_props #(.INT_N(INT_N)) rsp_pin_config_props_i (
   .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .flag_pin_in, .flag_pin_oe,
   .core_mem_req, .core_mem_we, .core_addr, .ext_address_bus, .ext_data_bus_oe,
   .host_port_select_n, .host_read_strobe_n, .host_port_ack_n, .second_serial_port_oe,
   .bus_request_in_n, .bus_grant_out_n, .grant_hung_out_n
);

// ==== rsp_ext_model.sv ====
/* far side model: strap driver, pin pulls and external memory.
   assumes pin enables high while the block drives. */
`timescale 1ns/1ps

module rsp_ext_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic strap_lvl,
   input wire logic [7:0] ext_drv,
   input wire logic [7:0] flag_pin_out,
   input wire logic [7:0] flag_pin_oe,
   output logic [7:0] flag_pin_in,
   input wire logic [13:0] ext_address_bus,
   input wire logic [23:0] ext_data_bus_out,
   input wire logic [23:0] ext_data_bus_oe,
   output logic [23:0] ext_data_bus_in
);
   logic rst_d;
   logic strap_on;
   logic [7:0] outside;
   logic [23:0] mem [16];

   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 24'h5a5a00 ^ 24'(i);
      end
   end

   // strap driver follows reset, one cycle hold, then floats
   always @(posedge clk) begin
      rst_d <= sys_rst;
      if (ext_data_bus_oe[8]) begin
         mem[ext_address_bus[3:0]] <= ext_data_bus_out;
      end
   end

   assign strap_on = sys_rst | rst_d;
   // pulls hold undriven pins
   assign outside = {ext_drv[7:3], strap_on ? strap_lvl : ext_drv[2], ext_drv[1:0]};
   assign flag_pin_in = (flag_pin_oe & flag_pin_out) | (~flag_pin_oe & outside);
   assign ext_data_bus_in = (ext_data_bus_oe & ext_data_bus_out)
      | (~ext_data_bus_oe & mem[ext_address_bus[3:0]]);
endmodule

// ==== tb_rsp_pin_config.sv ====
/* testbench of the pin configuration block.
   assumes the bound checker and the far side model. */
`timescale 1ns/1ps
`include "rsp_defines.svh"

module tb_rsp_pin_config;
   logic clk = 1'b0;
   logic sys_rst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, v;
   logic irq_out, strap_lvl = 1'b0;
   logic [7:0] flag_pin_in, flag_pin_out, flag_pin_oe, ext_drv = 8'hff;
   logic core_mem_req = 1'b0, core_mem_we = 1'b0, core_byte_acc = 1'b0;
   logic [13:0] core_addr = 14'h2a5, ext_address_bus;
   logic [7:0] core_byte_page = 8'h00;
   logic [23:0] core_wdata = 24'habcdef, core_rdata;
   logic [23:0] ext_data_bus_in, ext_data_bus_out, ext_data_bus_oe;
   logic host_port_select_n = 1'b1, host_read_strobe_n = 1'b1;
   logic host_write_strobe_n = 1'b1, host_addr_latch = 1'b0, host_port_ack_n;
   logic [15:0] host_addr_data_bus_in = 16'h0042, host_dma_rdata = 16'h1357;
   logic [15:0] host_addr_data_bus_out, host_addr_data_bus_oe, host_dma_addr, host_dma_wdata;
   logic host_dma_wr;
   logic [4:0] second_serial_port_in = 5'h1f, second_serial_port_out, second_serial_port_oe;
   logic [4:0] sp_core_out = 5'h0a, sp_core_oe = 5'h15, sp_core_in;
   logic bus_request_in_n = 1'b1, bus_grant_out_n, grant_hung_out_n;
   int miscompares = 0;
   int tests_run = 0;

   rsp_pin_config rsp_pin_config_i (
      .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq_out,
      .flag_pin_in, .flag_pin_out, .flag_pin_oe, .core_mem_req, .core_mem_we,
      .core_byte_acc, .core_addr, .core_byte_page, .core_wdata, .core_rdata,
      .ext_address_bus, .ext_data_bus_in, .ext_data_bus_out, .ext_data_bus_oe,
      .host_port_select_n, .host_read_strobe_n, .host_write_strobe_n, .host_addr_latch,
      .host_addr_data_bus_in, .host_addr_data_bus_out, .host_addr_data_bus_oe,
      .host_port_ack_n, .host_dma_rdata, .host_dma_addr, .host_dma_wdata, .host_dma_wr,
      .second_serial_port_in, .second_serial_port_out, .second_serial_port_oe,
      .sp_core_out, .sp_core_oe, .sp_core_in, .bus_request_in_n, .bus_grant_out_n,
      .grant_hung_out_n
   );

   rsp_ext_model rsp_ext_model_i (
      .clk, .sys_rst, .strap_lvl, .ext_drv, .flag_pin_out, .flag_pin_oe, .flag_pin_in,
      .ext_address_bus, .ext_data_bus_out, .ext_data_bus_oe, .ext_data_bus_in
   );

   initial begin
      forever #2 clk = ~clk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic do_reset(input logic s);
      sys_rst <= 1'b1;
      strap_lvl <= s;
      cyc(20);
      chk(flag_pin_oe, 8'h00);
      sys_rst <= 1'b0;
      cyc(3);
   endtask

   initial begin
      do_reset(1'b0);
      core_mem_req <= 1'b1;
      core_mem_we <= 1'b1;
      cyc(2);
      chk(ext_address_bus, 14'h2a5);
      chk(ext_data_bus_oe, 24'hffffff);
      chk(ext_data_bus_out, 24'habcdef);
      core_mem_we <= 1'b0;
      core_byte_acc <= 1'b1;
      core_byte_page <= 8'h5c;
      cyc(2);
      chk(ext_data_bus_oe, 24'hff0000);
      chk(ext_data_bus_out[23:16], 8'h5c);
      core_byte_acc <= 1'b0;
      cyc(3);
      chk(core_rdata, 24'habcdef);
      core_mem_req <= 1'b0;
      host_port_select_n <= 1'b0;
      host_read_strobe_n <= 1'b0;
      cyc(3);
      chk(host_port_ack_n, 1'b1);
      host_port_select_n <= 1'b1;
      host_read_strobe_n <= 1'b1;
      rd(`RSP_OFF_STATUS);
      chk(v, 32'h0);
      wr(`RSP_OFF_FLAG_DIR, 32'h07);
      wr(`RSP_OFF_FLAG_OUT, 32'h005);
      cyc(2);
      chk(flag_pin_oe, 8'h07);
      chk(flag_pin_out[2:0], 3'h5);
      rd(`RSP_OFF_FLAG_IN);
      chk(v[7:0], 8'hfd);
      $display("full mode done");
      wr(`RSP_OFF_INT_MASK, 32'h3f);
      ext_drv <= 8'hdf;
      cyc(3);
      chk(irq_out, 1'b1);
      rd(`RSP_OFF_INT_STAT);
      chk(v, 32'h02);
      ext_drv <= 8'haf;
      cyc(3);
      wr(`RSP_OFF_INT_STAT, 32'h0e);
      rd(`RSP_OFF_INT_STAT);
      chk(v, 32'h04);
      ext_drv <= 8'hdf;
      wr(`RSP_OFF_INT_MASK, 32'h0);
      cyc(3);
      wr(`RSP_OFF_INT_STAT, 32'h3f);
      rd(`RSP_OFF_INT_STAT);
      chk(v, 32'h02);
      chk(irq_out, 1'b0);
      ext_drv <= 8'hff;
      cyc(3);
      wr(`RSP_OFF_INT_STAT, 32'h3f);
      wr(`RSP_OFF_FLAG_DIR, 32'h87);
      cyc(3);
      rd(`RSP_OFF_INT_STAT);
      chk(v, 32'h01);
      wr(`RSP_OFF_CTRL, 32'h2);
      cyc(3);
      wr(`RSP_OFF_INT_STAT, 32'h3f);
      rd(`RSP_OFF_INT_STAT);
      chk(v, 32'h0);
      wr(`RSP_OFF_FLAG_DIR, 32'h07);
      $display("interrupt tests done");
      wr(`RSP_OFF_CTRL, 32'h1);
      wr(`RSP_OFF_FLAG_OUT, 32'h105);
      second_serial_port_in <= 5'h1e;
      cyc(3);
      chk(second_serial_port_oe, 5'h08);
      chk(second_serial_port_out[3], 1'b1);
      rd(`RSP_OFF_INT_STAT);
      chk(v, 32'h10);
      rd(`RSP_OFF_FLAG_IN);
      chk(v[8], 1'b1);
      wr(`RSP_OFF_CTRL, 32'h9);
      wr(`RSP_OFF_INT_STAT, 32'h3f);
      second_serial_port_in <= 5'h1c;
      cyc(3);
      rd(`RSP_OFF_INT_STAT);
      chk(v, 32'h30);
      wr(`RSP_OFF_INT_STAT, 32'h3f);
      rd(`RSP_OFF_INT_STAT);
      chk(v, 32'h10);
      wr(`RSP_OFF_CTRL, 32'h0);
      cyc(2);
      chk(second_serial_port_oe, 5'h15);
      chk(second_serial_port_out, 5'h0a);
      chk(sp_core_in, 5'h1c);
      second_serial_port_in <= 5'h1f;
      bus_request_in_n <= 1'b0;
      cyc(2);
      chk(bus_grant_out_n, 1'b0);
      core_mem_req <= 1'b1;
      core_mem_we <= 1'b1;
      cyc(2);
      chk(grant_hung_out_n, 1'b0);
      chk(ext_data_bus_oe, 24'h0);
      rd(`RSP_OFF_STATUS);
      chk(v, 32'h06);
      bus_request_in_n <= 1'b1;
      core_mem_req <= 1'b0;
      cyc(2);
      chk(bus_grant_out_n, 1'b1);
      $display("serial and bus tests done");
      do_reset(1'b1);
      rd(`RSP_OFF_STATUS);
      chk(v, 32'h01);
      core_mem_req <= 1'b1;
      cyc(2);
      chk(ext_address_bus, 14'h0001);
      chk(ext_data_bus_oe, 24'hffff00);
      chk(ext_data_bus_out[23:8], 16'habcd);
      core_mem_we <= 1'b0;
      cyc(3);
      chk(core_rdata, 24'habcd00);
      core_mem_req <= 1'b0;
      host_port_select_n <= 1'b0;
      host_read_strobe_n <= 1'b0;
      cyc(2);
      chk(host_port_ack_n, 1'b0);
      chk(host_addr_data_bus_oe, 16'hffff);
      chk(host_addr_data_bus_out, 16'h1357);
      host_read_strobe_n <= 1'b1;
      host_addr_latch <= 1'b1;
      cyc(1);
      host_addr_latch <= 1'b0;
      host_addr_data_bus_in <= 16'h9abc;
      host_write_strobe_n <= 1'b0;
      cyc(2);
      chk(host_dma_addr, 16'h0042);
      chk(host_dma_wdata, 16'h9abc);
      chk(host_addr_data_bus_oe, 16'h0000);
      host_port_select_n <= 1'b1;
      host_write_strobe_n <= 1'b1;
      cyc(1);
      chk(host_dma_wr, 1'b1);
      cyc(1);
      chk(host_dma_wr, 1'b0);
      chk(host_port_ack_n, 1'b1);
      $display("host mode done");
      stop_test();
   end

   // bound well above the length of the sequence
   initial begin
      #20000;
      miscompares++;
      stop_test();
   end
endmodule
